/* File: lpc_slave_status_reset_bits_tb.sv */
/*
 * Self-checking bench for the status and soft reset register block.
 * Assumes lpcsr_pkg, lpcsr_top and lpcsr_host_model are compiled first.
 */
module lpc_slave_status_reset_bits_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// signals and design
	// ----------------------------------------
	logic clk, rst_n, psel, penable, pwrite, lreset_n, lpcpd_n, irq_pending, run;
	logic [11:0] paddr;
	logic [3:0] pstrb;
	logic [31:0] pwdata, prdata, rdata;
	logic pready, pslverr, serirq_out, serirq_oe, lpc_reset, lclk, err;
	lpcsr_pkg::lpcsr_link_ev_t ev;
	int fail_count, n_checks, cycles;
	localparam lpcsr_pkg::lpcsr_link_ev_t MATCH = 5'h10, DONE = 5'h08, ABORT = 5'h04;
	localparam lpcsr_pkg::lpcsr_link_ev_t FSTART = 5'h02, FEND = 5'h01;
	localparam logic [11:0] STAT = 12'h000, CTRL = 12'h004;

	lpcsr_top #(.STOP_CYC(4)) dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.LCLK(lclk), .LINK_EV(ev), .LRESET_N(lreset_n), .LPCPD_N(lpcpd_n),
		.IRQ_PENDING(irq_pending), .SERIRQ_OUT(serirq_out), .SERIRQ_OE(serirq_oe),
		.LPC_RESET(lpc_reset));
	lpcsr_host_model host (.run(run), .lclk(lclk), .ev(ev));

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic report_and_stop;
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// held until pready is sampled high; the global timeout bounds the wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), exp, rdata);
	endtask

	task automatic settle;
		repeat (10) @(posedge clk);
	endtask

	task automatic ev_send(input lpcsr_pkg::lpcsr_link_ev_t e);
		host.send(e);
		settle();
	endtask

	task automatic link_up;
		while (lpc_reset !== 1'b0) @(posedge clk);
		settle();
	endtask

	task automatic hw_reset;
		lreset_n <= 1'b0;
		settle();
		chk("reset out in pin reset", 32'h1, {31'h0, lpc_reset});
		lreset_n <= 1'b1;
		link_up();
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite, irq_pending} = 4'h0;
		{lreset_n, lpcpd_n, run} = 3'h7;
		pstrb = 4'hf;
		paddr = 12'h000;
		pwdata = 32'h0;
		{fail_count, n_checks, cycles} = {32'h0, 32'h0, 32'h0};
		repeat (10) @(posedge clk);
		chk("reset out in reset", 32'h1, {31'h0, lpc_reset});
		rst_n <= 1'b1;
		link_up();
		rd(STAT, 32'h0);
		rd(CTRL, 32'h0);
		rd(12'h008, 32'h0);
		chk("slave error", 32'h1, {31'h0, err});
		apb(1'b1, STAT, 32'h000000e0);
		rd(STAT, 32'h0);
		ev_send(MATCH);
		rd(STAT, 32'h80);
		apb(1'b1, STAT, 32'h0);
		rd(STAT, 32'h80);
		ev_send(DONE);
		rd(STAT, 32'h0);
		ev_send(MATCH);
		rd(STAT, 32'h80);
		ev_send(ABORT);
		rd(STAT, 32'h0);
		ev_send(FSTART);
		rd(STAT, 32'h20);
		ev_send(FEND);
		rd(STAT, 32'h0);
		// write of one without a fresh zero read is refused
		apb(1'b1, STAT, 32'h0);
		apb(1'b1, STAT, 32'h10);
		rd(STAT, 32'h0);
		// a write without byte lane 0 does not land
		pstrb <= 4'he;
		apb(1'b1, STAT, 32'h10);
		pstrb <= 4'hf;
		rd(STAT, 32'h0);
		apb(1'b1, STAT, 32'h10);
		rd(STAT, 32'h10);
		chk("soft reset out", 32'h1, {31'h0, lpc_reset});
		host.send(MATCH);
		apb(1'b1, STAT, 32'h0);
		link_up();
		rd(STAT, 32'h0);
		ev_send(MATCH);
		ev_send(FSTART);
		rd(STAT, 32'ha0);
		apb(1'b1, STAT, 32'h10);
		rd(STAT, 32'h10);
		hw_reset();
		rd(STAT, 32'h0);
		ev_send(MATCH);
		rd(STAT, 32'h80);
		hw_reset();
		rd(STAT, 32'h0);
		ev_send(MATCH);
		rd(STAT, 32'h80);
		apb(1'b1, CTRL, 32'h4);
		settle();
		chk("sw shutdown out", 32'h1, {31'h0, lpc_reset});
		rd(STAT, 32'h0);
		apb(1'b1, CTRL, 32'h2);
		link_up();
		ev_send(MATCH);
		rd(STAT, 32'h80);
		lpcpd_n <= 1'b0;
		settle();
		chk("hw shutdown out", 32'h1, {31'h0, lpc_reset});
		rd(STAT, 32'h0);
		// power-down without the enable leaves the interface running
		apb(1'b1, CTRL, 32'h1);
		link_up();
		chk("power-down unenabled", 32'h0, {31'h0, lpc_reset});
		lpcpd_n <= 1'b1;
		irq_pending <= 1'b1;
		run <= 1'b0;
		settle();
		rd(STAT, 32'h40);
		chk("serial irq drive", 32'h1, {31'h0, serirq_oe});
		irq_pending <= 1'b0;
		settle();
		rd(STAT, 32'h0);
		chk("serial irq drive", 32'h0, {31'h0, serirq_oe});
		irq_pending <= 1'b1;
		settle();
		rd(STAT, 32'h40);
		apb(1'b1, CTRL, 32'h0);
		rd(STAT, 32'h0);
		chk("serial irq drive", 32'h0, {31'h0, serirq_oe});
		apb(1'b1, CTRL, 32'h1);
		settle();
		rd(STAT, 32'h40);
		apb(1'b1, CTRL, 32'h5);
		rd(STAT, 32'h0);
		apb(1'b1, CTRL, 32'h1);
		run <= 1'b1;
		settle();
		chk("serial irq drive", 32'h0, {31'h0, serirq_oe});
		chk("serial irq data", 32'h0, {31'h0, serirq_out});
		report_and_stop();
	end
endmodule

/* File: lpcsr_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts of the LPC
 * status and soft reset register block.
 * Assumes inclusion by bare name from the top module.
 */
`ifndef LPCSR_CFG_SVH
`define LPCSR_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define LPCSR_ADDR_W 12
`define LPCSR_STAT_OFS 12'h000
`define LPCSR_CTRL_OFS 12'h004

// ----------------------------------------
// status register fields
// ----------------------------------------
`define LPCSR_CYC_BUSY_BIT 7
`define LPCSR_CLK_REQ_BIT 6
`define LPCSR_IRQ_BUSY_BIT 5
`define LPCSR_SOFT_RST_BIT 4
`define LPCSR_STAT_RESET 8'h00

// ----------------------------------------
// control register fields
// ----------------------------------------
`define LPCSR_QUIET_BIT 0
`define LPCSR_HW_SD_EN_BIT 1
`define LPCSR_SW_SD_BIT 2
`define LPCSR_CTRL_RESET 3'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define LPCSR_CLK_PERIOD_NS 25
`define LPCSR_LCLK_STOP_NS 100
`define LPCSR_LCLK_STOP_CYC \
	((`LPCSR_LCLK_STOP_NS + `LPCSR_CLK_PERIOD_NS - 1) / `LPCSR_CLK_PERIOD_NS)

`endif

/* File: lpcsr_host_model.sv */
/*
 * Host chipset stand-in: makes LCLK and pulses link cycle/frame events.
 * Assumes the bench gates LCLK with run and calls send only while it runs.
 */
module lpcsr_host_model (
	input wire logic run,
	output logic lclk,
	output lpcsr_pkg::lpcsr_link_ev_t ev
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// link clock and events
	// ----------------------------------------
	// odd start offset keeps LCLK unrelated to CLK; stops where it stands
	initial begin
		lclk = 1'b0;
		ev = '0;
		#3;
		forever begin
			#6;
			if (run) begin
				lclk = ~lclk;
			end
		end
	end

	task automatic send(input lpcsr_pkg::lpcsr_link_ev_t e);
		@(posedge lclk);
		ev <= e;
		@(posedge lclk);
		ev <= '0;
	endtask
endmodule

/* File: lpcsr_link.sv */
/*
 * Link-clock side: busy levels for transfer cycles and serial irq frames,
 * plus a heartbeat toggle that lets the system side see LCLK running.
 * Assumes event inputs come from logic already on LCLK.
 */
module lpcsr_link (
	input wire logic lclk,
	input wire logic rst_n,
	input wire lpcsr_pkg::lpcsr_link_ev_t ev,
	output logic cyc_busy,
	output logic irq_busy,
	output logic heartbeat
);
	logic hb_div_reg;

	// ----------------------------------------
	// cycle busy: set wins over a clear in the same cycle
	// ----------------------------------------
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_busy <= 1'b0;
		end else if (ev.cyc_match) begin
			cyc_busy <= 1'b1;
		end else if (ev.cyc_done || ev.cyc_abort) begin
			cyc_busy <= 1'b0;
		end
	end

	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_busy <= 1'b0;
		end else if (ev.frame_start) begin
			irq_busy <= 1'b1;
		end else if (ev.frame_end) begin
			irq_busy <= 1'b0;
		end
	end

	// half rate: a toggle per LCLK would alias against CLK and look stopped
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			hb_div_reg <= 1'b0;
			heartbeat <= 1'b0;
		end else begin
			hb_div_reg <= ~hb_div_reg;
			if (hb_div_reg) begin
				heartbeat <= ~heartbeat;
			end
		end
	end
endmodule

/* File: lpcsr_pkg.sv */
/*
 * Types shared by the LPC status and soft reset register block.
 * Assumes nothing beyond the configuration header.
 */
package lpcsr_pkg;

	// ----------------------------------------
	// link-side events, one LCLK cycle each
	// ----------------------------------------
	typedef struct packed {
		logic cyc_match;
		logic cyc_done;
		logic cyc_abort;
		logic frame_start;
		logic frame_end;
	} lpcsr_link_ev_t;

	typedef struct packed {
		logic sw_shutdown;
		logic hw_shutdown_en;
		logic quiet_mode;
	} lpcsr_ctrl_t;

	typedef enum logic [1:0] {
		LPCSR_SEL_NONE = 2'b00,
		LPCSR_SEL_STAT = 2'b01,
		LPCSR_SEL_CTRL = 2'b10
	} lpcsr_sel_t;

endpackage

/* File: lpcsr_sync.sv */
/*
 * Two-flop level synchroniser, one stage pair per bit.
 * Assumes inputs are levels that stay put for several destination cycles.
 */
module lpcsr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

/* File: lpcsr_top.sv */
/*
 * APB-mapped LPC status and soft reset register with its link-side busy
 * tracking, LCLK restart request and LPC interface reset generation.
 * Assumes an APB master on CLK, an LPC protocol engine on LCLK that
 * reports cycle and frame events, and pins LRESET_N/LPCPD_N from outside.
 */
`include "lpcsr_cfg.svh"

module lpcsr_top #(
	parameter int STOP_CYC = `LPCSR_LCLK_STOP_CYC
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [`LPCSR_ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic LCLK,
	input wire lpcsr_pkg::lpcsr_link_ev_t LINK_EV,
	input wire logic LRESET_N,
	input wire logic LPCPD_N,
	input wire logic IRQ_PENDING,
	output logic SERIRQ_OUT,
	output logic SERIRQ_OE,
	output logic LPC_RESET
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic setup;
	logic access;
	logic wr_stat;
	logic wr_ctrl;
	logic rd_stat;
	lpcsr_pkg::lpcsr_sel_t sel;
	logic [31:0] rdata_next;
	lpcsr_pkg::lpcsr_ctrl_t ctrl_reg;
	logic cyc_busy_reg;
	logic clk_req_reg;
	logic clk_req_next;
	logic irq_busy_reg;
	logic soft_reset_reg;
	logic zero_read_reg;
	logic lpc_reset_next;
	logic link_rst_n;
	logic link_cyc_busy;
	logic link_irq_busy;
	logic link_hb;
	logic [2:0] link_s;
	logic [1:0] pin_s;
	logic lreset_s;
	logic lpcpd_s;
	logic hb_prev_reg;
	logic [15:0] idle_cnt_reg;
	logic lclk_stopped;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE && PREADY;

	always_comb begin
		unique case (PADDR)
			`LPCSR_STAT_OFS: sel = lpcsr_pkg::LPCSR_SEL_STAT;
			`LPCSR_CTRL_OFS: sel = lpcsr_pkg::LPCSR_SEL_CTRL;
			default: sel = lpcsr_pkg::LPCSR_SEL_NONE;
		endcase
	end

	// writes land only on the low byte lane, where all fields live
	assign wr_stat = access && PWRITE && PSTRB[0] && (sel == lpcsr_pkg::LPCSR_SEL_STAT);
	assign wr_ctrl = access && PWRITE && PSTRB[0] && (sel == lpcsr_pkg::LPCSR_SEL_CTRL);
	assign rd_stat = access && !PWRITE && (sel == lpcsr_pkg::LPCSR_SEL_STAT);

	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (sel)
			lpcsr_pkg::LPCSR_SEL_STAT: begin
				rdata_next[`LPCSR_CYC_BUSY_BIT] = cyc_busy_reg;
				rdata_next[`LPCSR_CLK_REQ_BIT] = clk_req_reg;
				rdata_next[`LPCSR_IRQ_BUSY_BIT] = irq_busy_reg;
				rdata_next[`LPCSR_SOFT_RST_BIT] = soft_reset_reg;
			end
			lpcsr_pkg::LPCSR_SEL_CTRL: begin
				rdata_next[2:0] = ctrl_reg;
			end
			lpcsr_pkg::LPCSR_SEL_NONE: begin
				rdata_next = 32'h0000_0000;
			end
		endcase
	end

	// one wait state: answer is registered at the setup edge
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= setup;
			PRDATA <= setup ? rdata_next : 32'h0000_0000;
			PSLVERR <= setup && (sel == lpcsr_pkg::LPCSR_SEL_NONE);
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg <= `LPCSR_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg.quiet_mode <= PWDATA[`LPCSR_QUIET_BIT];
			ctrl_reg.hw_shutdown_en <= PWDATA[`LPCSR_HW_SD_EN_BIT];
			ctrl_reg.sw_shutdown <= PWDATA[`LPCSR_SW_SD_BIT];
		end
	end

	// ----------------------------------------
	// pin and link crossings
	// ----------------------------------------
	lpcsr_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.d({LRESET_N, LPCPD_N}),
		.q(pin_s)
	);

	assign lreset_s = pin_s[1];
	assign lpcpd_s = pin_s[0];

	// link flops are held while the lpc interface is in reset
	assign link_rst_n = RST_N && !LPC_RESET;

	lpcsr_link u_link (
		.lclk(LCLK),
		.rst_n(link_rst_n),
		.ev(LINK_EV),
		.cyc_busy(link_cyc_busy),
		.irq_busy(link_irq_busy),
		.heartbeat(link_hb)
	);

	lpcsr_sync #(
		.WIDTH(3)
	) u_link_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.d({link_cyc_busy, link_irq_busy, link_hb}),
		.q(link_s)
	);

	// ----------------------------------------
	// lpc interface reset and shutdown
	// ----------------------------------------
	// pin reset, soft reset, software shutdown, or power-down shutdown when enabled
	assign lpc_reset_next = !lreset_s || soft_reset_reg || ctrl_reg.sw_shutdown
		|| (ctrl_reg.hw_shutdown_en && !lpcpd_s);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			LPC_RESET <= 1'b1;
		end else begin
			LPC_RESET <= lpc_reset_next;
		end
	end

	// ----------------------------------------
	// busy flags
	// ----------------------------------------
	// follow link busy
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cyc_busy_reg <= 1'b0;
		end else begin
			cyc_busy_reg <= link_s[2] && !LPC_RESET && !lpc_reset_next;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_busy_reg <= 1'b0;
		end else begin
			irq_busy_reg <= link_s[1] && !LPC_RESET && !lpc_reset_next;
		end
	end

	// ----------------------------------------
	// lclk stop detection
	// ----------------------------------------
	// a heartbeat that stops toggling means LCLK has stopped
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			hb_prev_reg <= 1'b0;
			idle_cnt_reg <= 16'h0000;
		end else begin
			hb_prev_reg <= link_s[0];
			if (link_s[0] != hb_prev_reg) begin
				idle_cnt_reg <= 16'h0000;
			end else if (idle_cnt_reg < 16'(STOP_CYC)) begin
				idle_cnt_reg <= idle_cnt_reg + 16'h0001;
			end
		end
	end

	// held link reset also stops the heartbeat
	assign lclk_stopped = (idle_cnt_reg >= 16'(STOP_CYC));

	// ----------------------------------------
	// lclk restart request
	// ----------------------------------------
	always_comb begin
		clk_req_next = clk_req_reg;
		if (lpc_reset_next || LPC_RESET || !ctrl_reg.quiet_mode || !IRQ_PENDING) begin
			clk_req_next = 1'b0;
		end else if (lclk_stopped) begin
			clk_req_next = 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			clk_req_reg <= 1'b0;
		end else begin
			clk_req_reg <= clk_req_next;
		end
	end

	// pull the serial irq line low while a restart request is up and LCLK is stopped
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SERIRQ_OUT <= 1'b0;
			SERIRQ_OE <= 1'b0;
		end else begin
			SERIRQ_OUT <= 1'b0;
			SERIRQ_OE <= clk_req_next && lclk_stopped;
		end
	end

	// ----------------------------------------
	// soft reset bit
	// ----------------------------------------
	// arm on a read that saw zero
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			zero_read_reg <= 1'b0;
		end else if (!lreset_s || wr_stat) begin
			zero_read_reg <= 1'b0;
		end else if (rd_stat) begin
			zero_read_reg <= !soft_reset_reg;
		end
	end

	// only the soft reset field is writable
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			soft_reset_reg <= 1'b0;
		end else if (!lreset_s) begin
			soft_reset_reg <= 1'b0;
		end else if (wr_stat) begin
			if (!PWDATA[`LPCSR_SOFT_RST_BIT]) begin
				soft_reset_reg <= 1'b0;
			end else if (zero_read_reg) begin
				soft_reset_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_apb_setup;
		PSEL && !PENABLE;
	endsequence

	sequence s_apb_answer;
		PREADY ##1 !PREADY;
	endsequence

	a_apb_one_wait: assert property (s_apb_setup |=> s_apb_answer)
		else $error("apb answer not one wait state");

	a_cyc_busy_rise: assert property (
		(link_s[2] && !lpc_reset_next && !LPC_RESET) |=> cyc_busy_reg)
		else $error("cycle busy not set after match");

	a_cyc_busy_fall: assert property (
		!link_s[2] |=> !cyc_busy_reg)
		else $error("cycle busy not cleared");

	a_flags_reset: assert property (
		LPC_RESET |=> !cyc_busy_reg && !irq_busy_reg && !clk_req_reg)
		else $error("flags survive lpc reset");

	a_irq_busy_track: assert property (
		$rose(link_s[1]) && !lpc_reset_next && !LPC_RESET |=> irq_busy_reg)
		else $error("irq busy not set at frame start");

	a_link_clock_restart_request_set: assert property (
		(ctrl_reg.quiet_mode && IRQ_PENDING && lclk_stopped && !lpc_reset_next && !LPC_RESET)
		|=> clk_req_reg ##0 SERIRQ_OE)
		else $error("restart request not raised");

	a_link_clock_restart_request_clear: assert property (
		(!ctrl_reg.quiet_mode || !IRQ_PENDING) |=> !clk_req_reg && !SERIRQ_OE)
		else $error("restart request not dropped");

	a_srst_guard: assert property (
		(wr_stat && PWDATA[`LPCSR_SOFT_RST_BIT] && !zero_read_reg && !soft_reset_reg)
		|=> !soft_reset_reg)
		else $error("soft reset set without zero read");

	a_srst_hold: assert property (
		soft_reset_reg |=> LPC_RESET && !cyc_busy_reg && !irq_busy_reg)
		else $error("interface not held in soft reset");

	a_hw_shutdown: assert property (
		(ctrl_reg.hw_shutdown_en && !lpcpd_s) |=> LPC_RESET ##1 !cyc_busy_reg)
		else $error("power-down did not shut down");

	a_ro_ignore: assert property (
		wr_stat && !link_s[2] |=> !cyc_busy_reg)
		else $error("status write reached busy flag");
endmodule
